// ---- verilog/irq_wake_pkg.sv ----
// Purpose: Shared constants for the interrupt enable and low-power wake block
// Assumes: Avalon-MM register slave, 32-bit data, byte addresses
// Notes: Offsets other than the enable mask placement are local choices
package irq_wake_pkg;
    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] ADDR_IE = 4'h0;
    localparam logic [3:0] ADDR_T2CTL = 4'h4;
    localparam logic [3:0] ADDR_PWR = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hc;

    // ************************************************************
    // Enable mask fields
    // ************************************************************
    localparam int IE_GLOBAL_BIT = 7;
    localparam int IE_RSVD_BIT = 6;
    localparam int IE_T2_BIT = 5;
    localparam int IE_SER_BIT = 4;
    localparam int IE_T1_BIT = 3;
    localparam int IE_X1_BIT = 2;
    localparam int IE_T0_BIT = 1;
    localparam int IE_X0_BIT = 0;
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam logic [7:0] IE_WRITABLE = 8'hbf;

    // ************************************************************
    // Timer 2 control fields
    // ************************************************************
    localparam int T2_OVF_BIT = 7;
    localparam int T2_EXT_BIT = 6;
    localparam int T2_TRIG_EN_BIT = 3;
    localparam logic [7:0] T2CTL_RESET = 8'h00;

    // ************************************************************
    // Power control fields and timing
    // ************************************************************
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_DOWN_BIT = 1;
    localparam int STATES_PER_CYCLE = 6;
    localparam int RESUME_CYCLES = 2;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_DOWN
    } power_mode_t;

    typedef enum logic [1:0] {
        T2_CAPTURE,
        T2_RELOAD_UP,
        T2_RELOAD_UPDOWN,
        T2_BAUD
    } t2_mode_t;
endpackage : irq_wake_pkg

// ---- verilog/irq_req_if.sv ----
// Purpose: Carrier for raw request sources and enable bits into the priority gate
// Assumes: One clock domain
// Notes: Six sources, order ext0, t0, ext1, t1, serial, t2
`timescale 1ns/1ps
interface irq_req_if;
    logic [5:0] raw;
    logic [5:0] enable;
    logic global_allow;
    logic [5:0] gated;
    logic any;
    modport src (output raw, output enable, output global_allow, input gated, input any);
    modport gate (input raw, input enable, input global_allow, output gated, output any);
endinterface : irq_req_if

// ---- verilog/irq_gate.sv ----
// Purpose: Masks the six request sources with per-source and global allow bits
// Assumes: Inputs already sampled at the proper machine-cycle point
// Notes: Purely combinational
`timescale 1ns/1ps
module irq_gate (
    // Request carrier
    irq_req_if.gate req
);
    // Per-source masking; global allow overrides everything
    assign req.gated = req.global_allow ? (req.raw & req.enable) : 6'h00;
    assign req.any = |req.gated;
endmodule : irq_gate

// ---- verilog/irq_wake_ctrl.sv ----
// Purpose: Interrupt enable mask, timer 2 flag merge and idle / power-down control
// Assumes: Timers, serial port and core live outside; core_clk is the machine clock
// Notes: Registers reached over Avalon-MM, waitrequest low on the cycle after the strobe
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module irq_wake_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Machine-cycle state strobes from the clock generator
    input wire logic state2_phase2,
    input wire logic state5_phase2,
    // Request sources
    input wire logic ext_request_0,
    input wire logic ext_request_1,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    input wire logic serial_irq,
    input wire logic timer2_external_input,
    input wire logic [1:0] timer2_mode,
    // Core handshake
    input wire logic irq_ack,
    input wire logic [2:0] irq_ack_vector,
    input wire logic ext_prog_mem,
    output logic irq_pending,
    output logic [2:0] irq_vector,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag,
    // Power and pin control
    output logic cpu_halt,
    output logic osc_stop,
    output logic ram_access_block,
    output logic addr_latch_strobe,
    output logic prog_store_strobe,
    output logic port0_float,
    output logic port2_drive_addr
);
    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] interrupt_enable_mask_ff;
    logic timer2_overflow_flag_ff;
    logic timer2_external_flag_ff;
    logic timer2_external_trigger_enable_ff;
    logic t0_flag_ff;
    logic t1_flag_ff;
    logic t0_seen_ff;
    logic t1_seen_ff;
    logic [5:0] sampled_ff;
    logic timer2_external_input_prev_ff;
    logic ack_ff;
    logic [1:0] resume_cnt_ff;
    logic pending_ff;
    logic [2:0] vector_ff;
    irq_wake_pkg::power_mode_t mode_ff;
    irq_wake_pkg::t2_mode_t t2m;
    logic wr_hit;
    logic t2_fall;
    logic t2_request;
    irq_req_if req ();

    assign t2m = irq_wake_pkg::t2_mode_t'(timer2_mode);
    assign wr_hit = avs_write && ack_ff; // Lands only at the edge where waitrequest is low
    assign t2_fall = timer2_external_input_prev_ff && !timer2_external_input;

    // ************************************************************
    // Bus slave: one wait cycle, then answer
    // ************************************************************
    // Waitrequest drops one cycle after the strobe so write and read share one timing
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_ff) begin
            case (avs_address)
                irq_wake_pkg::ADDR_IE: avs_readdata <= {24'h0, interrupt_enable_mask_ff};
                irq_wake_pkg::ADDR_T2CTL: avs_readdata <= {24'h0, timer2_overflow_flag_ff,
                    timer2_external_flag_ff, 2'b00, timer2_external_trigger_enable_ff, 3'b000};
                irq_wake_pkg::ADDR_PWR: avs_readdata <= {30'h0, mode_ff == irq_wake_pkg::PM_DOWN,
                    mode_ff == irq_wake_pkg::PM_IDLE};
                irq_wake_pkg::ADDR_STAT: avs_readdata <= {26'h0, sampled_ff};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // ************************************************************
    // Enable mask
    // ************************************************************
    // Reserved bit 6 is not stored so a stray one cannot leak into future use
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_enable_mask_ff <= irq_wake_pkg::IE_RESET;
        end else if (wr_hit && avs_address == irq_wake_pkg::ADDR_IE) begin
            interrupt_enable_mask_ff <= avs_writedata[7:0] & irq_wake_pkg::IE_WRITABLE;
        end
    end

    // ************************************************************
    // Timer 2 control and flags
    // ************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer2_external_trigger_enable_ff <= 1'b0;
        end else if (wr_hit && avs_address == irq_wake_pkg::ADDR_T2CTL) begin
            timer2_external_trigger_enable_ff <= avs_writedata[irq_wake_pkg::T2_TRIG_EN_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer2_external_input_prev_ff <= 1'b1;
        end else begin
            timer2_external_input_prev_ff <= timer2_external_input;
        end
    end

    // Overflow flag set at state 2; baud mode rollovers leave it alone; set beats clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer2_overflow_flag_ff <= 1'b0;
        end else if (timer2_overflow && state2_phase2 && t2m != irq_wake_pkg::T2_BAUD) begin
            timer2_overflow_flag_ff <= 1'b1;
        end else if (wr_hit && avs_address == irq_wake_pkg::ADDR_T2CTL) begin
            timer2_overflow_flag_ff <= avs_writedata[irq_wake_pkg::T2_OVF_BIT];
        end
    end

    // External flag: falling edge sets it, up/down mode toggles on roll; no ack clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer2_external_flag_ff <= 1'b0;
        end else if (t2m == irq_wake_pkg::T2_RELOAD_UPDOWN) begin
            if (timer2_overflow && state2_phase2) begin
                timer2_external_flag_ff <= !timer2_external_flag_ff;
            end else if (wr_hit && avs_address == irq_wake_pkg::ADDR_T2CTL) begin
                timer2_external_flag_ff <= avs_writedata[irq_wake_pkg::T2_EXT_BIT];
            end
        end else if (t2_fall && timer2_external_trigger_enable_ff) begin
            timer2_external_flag_ff <= 1'b1;
        end else if (wr_hit && avs_address == irq_wake_pkg::ADDR_T2CTL) begin
            timer2_external_flag_ff <= avs_writedata[irq_wake_pkg::T2_EXT_BIT];
        end
    end

    // Toggled flag in up/down mode is a count bit, not a request
    assign t2_request = timer2_overflow_flag_ff ||
        (timer2_external_flag_ff && t2m != irq_wake_pkg::T2_RELOAD_UPDOWN);

    // ************************************************************
    // Timer 0/1 flags: set at state 5, cleared by hardware on vectoring
    // ************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            t0_flag_ff <= 1'b0;
            t1_flag_ff <= 1'b0;
        end else begin
            if (timer0_overflow && state5_phase2) begin
                t0_flag_ff <= 1'b1;
            end else if (irq_ack && irq_ack_vector == 3'h1) begin
                t0_flag_ff <= 1'b0;
            end
            if (timer1_overflow && state5_phase2) begin
                t1_flag_ff <= 1'b1;
            end else if (irq_ack && irq_ack_vector == 3'h3) begin
                t1_flag_ff <= 1'b0;
            end
        end
    end
    assign timer0_overflow_flag = t0_flag_ff;
    assign timer1_overflow_flag = t1_flag_ff;

    // Polling point: the next state-2 strobe, i.e. the following machine cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            t0_seen_ff <= 1'b0;
            t1_seen_ff <= 1'b0;
        end else if (state2_phase2) begin
            t0_seen_ff <= t0_flag_ff;
            t1_seen_ff <= t1_flag_ff;
        end
    end

    // ************************************************************
    // Sampling and gating of the six sources
    // ************************************************************
    // A timer 2 flag set at state 2 is already seen by this state-5 sample
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sampled_ff <= 6'h00;
        end else if (state5_phase2) begin
            sampled_ff <= {t2_request, serial_irq,
                t1_seen_ff, ext_request_1, t0_seen_ff, ext_request_0};
        end
    end

    assign req.raw = sampled_ff;
    assign req.enable = interrupt_enable_mask_ff[5:0];
    assign req.global_allow = interrupt_enable_mask_ff[irq_wake_pkg::IE_GLOBAL_BIT];

    irq_gate u_gate (
        .req(req)
    );

    // Fixed order vector: lowest index first
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_ff <= 1'b0;
            vector_ff <= 3'h0;
        end else begin
            pending_ff <= req.any;
            vector_ff <= req.gated[0] ? 3'h0 : req.gated[1] ? 3'h1 : req.gated[2] ? 3'h2 :
                req.gated[3] ? 3'h3 : req.gated[4] ? 3'h4 : 3'h5;
        end
    end
    assign irq_pending = pending_ff;
    assign irq_vector = vector_ff;

    // ************************************************************
    // Power modes
    // ************************************************************
    // Power-down ignores requests: only reset leaves it; idle leaves on enabled request
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= irq_wake_pkg::PM_RUN;
        end else begin
            case (mode_ff)
                irq_wake_pkg::PM_RUN: begin
                    if (wr_hit && avs_address == irq_wake_pkg::ADDR_PWR) begin
                        if (avs_writedata[irq_wake_pkg::PWR_DOWN_BIT]) begin
                            mode_ff <= irq_wake_pkg::PM_DOWN;
                        end else if (avs_writedata[irq_wake_pkg::PWR_IDLE_BIT]) begin
                            mode_ff <= irq_wake_pkg::PM_IDLE;
                        end
                    end
                end
                irq_wake_pkg::PM_IDLE: begin
                    if (req.any) begin
                        mode_ff <= irq_wake_pkg::PM_RUN;
                    end
                end
                irq_wake_pkg::PM_DOWN: mode_ff <= irq_wake_pkg::PM_DOWN;
                default: mode_ff <= irq_wake_pkg::PM_RUN;
            endcase
        end
    end

    // After a reset that ends idle the core may run briefly; RAM stays locked meanwhile
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            resume_cnt_ff <= 2'(irq_wake_pkg::RESUME_CYCLES);
        end else if (resume_cnt_ff != 2'h0 && state5_phase2) begin
            resume_cnt_ff <= resume_cnt_ff - 2'h1;
        end
    end
    assign ram_access_block = resume_cnt_ff != 2'h0;

    // Halt only stops the core; mask, flags and sampling above keep running
    assign cpu_halt = mode_ff != irq_wake_pkg::PM_RUN;
    assign osc_stop = mode_ff == irq_wake_pkg::PM_DOWN;
    assign addr_latch_strobe = mode_ff == irq_wake_pkg::PM_IDLE;
    assign prog_store_strobe = mode_ff == irq_wake_pkg::PM_IDLE;
    assign port0_float = mode_ff != irq_wake_pkg::PM_RUN && ext_prog_mem;
    assign port2_drive_addr = mode_ff == irq_wake_pkg::PM_IDLE && ext_prog_mem;
endmodule : irq_wake_ctrl

// ---- testbench/core_model.sv ----
// Purpose: Far-side model: machine-cycle strobes and core vectoring
// Assumes: Six clocks per machine cycle
// Notes: Acknowledges only while ack_en is high
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bench control
    input wire logic ack_en,
    // Block side
    input wire logic irq_pending,
    input wire logic [2:0] irq_vector,
    output logic state2_phase2,
    output logic state5_phase2,
    output logic irq_ack,
    output logic [2:0] irq_ack_vector
);
    logic [2:0] phase_ff;
    // Free-running state count; keeps going in idle so peripherals still tick
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff <= 3'h0;
        end else begin
            phase_ff <= (phase_ff == 3'h5) ? 3'h0 : phase_ff + 3'h1;
        end
    end
    assign state2_phase2 = (phase_ff == 3'h1);
    assign state5_phase2 = (phase_ff == 3'h4);
    // One ack pulse per vectoring; timer 2 flags are left for software
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ack <= 1'b0;
            irq_ack_vector <= 3'h0;
        end else begin
            irq_ack <= ack_en && irq_pending && !irq_ack;
            irq_ack_vector <= irq_vector;
        end
    end
endmodule : core_model

// ---- testbench/irq_wake_sva.sv ----
// Purpose: Port-level checks of the enable mask, wake and pin states
// Assumes: Single clock, async active-low reset
// Notes: Mask is shadowed from accepted bus writes
`timescale 1ns/1ps
module irq_wake_sva (
    // Clock, reset and bus
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // Sources and core
    input wire logic state5_phase2,
    input wire logic timer0_overflow,
    input wire logic ext_request_0,
    input wire logic ext_prog_mem,
    input wire logic irq_pending,
    input wire logic [2:0] irq_vector,
    input wire logic timer0_overflow_flag,
    // Power and pins
    input wire logic cpu_halt,
    input wire logic osc_stop,
    input wire logic ram_access_block,
    input wire logic addr_latch_strobe,
    input wire logic prog_store_strobe,
    input wire logic port0_float,
    input wire logic port2_drive_addr
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] ie_ff;
    // Shadow mask; reserved bit never sticks
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ie_ff <= 8'h00;
        end else if (avs_write && !avs_waitrequest && avs_address == irq_wake_pkg::ADDR_IE) begin
            ie_ff <= avs_writedata[7:0] & irq_wake_pkg::IE_WRITABLE;
        end
    end
    property p_bus_wait;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer not after one wait");
    property p_global_off;
        (!ie_ff[7]) [*3] |-> !irq_pending;
    endproperty
    a_global_off: assert property (p_global_off) else $error("request with global allow off");
    property p_vector_enabled;
        $stable(ie_ff) [*3] ##0 irq_pending |-> ie_ff[irq_vector];
    endproperty
    a_vector_enabled: assert property (p_vector_enabled) else $error("vector of masked source");
    property p_idle_pins;
        cpu_halt && !osc_stop |-> addr_latch_strobe && prog_store_strobe && port0_float == ext_prog_mem
            && port2_drive_addr == ext_prog_mem;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("idle pin states wrong");
    property p_down_pins;
        osc_stop |-> !addr_latch_strobe && !prog_store_strobe && !port2_drive_addr && port0_float == ext_prog_mem;
    endproperty
    a_down_pins: assert property (p_down_pins) else $error("power-down pin states wrong");
    property p_down_sticky;
        osc_stop |=> osc_stop;
    endproperty
    a_down_sticky: assert property (p_down_sticky) else $error("power-down left without reset");
    property p_idle_wake;
        cpu_halt && !osc_stop && ie_ff[7] && ie_ff[0] ##0 ext_request_0 [*6] |-> ##[0:2] !cpu_halt;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not left on request");
    property p_ram_block;
        $rose(reset_n) |-> ram_access_block ##[1:20] !ram_access_block;
    endproperty
    a_ram_block: assert property (p_ram_block) else $error("RAM block window wrong");
    property p_t0_flag;
        timer0_overflow && state5_phase2 |=> timer0_overflow_flag;
    endproperty
    a_t0_flag: assert property (p_t0_flag) else $error("timer 0 flag not set");
endmodule : irq_wake_sva
bind irq_wake_ctrl irq_wake_sva u_irq_wake_sva (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .state5_phase2(state5_phase2), .timer0_overflow(timer0_overflow),
    .ext_request_0(ext_request_0), .ext_prog_mem(ext_prog_mem), .irq_pending(irq_pending), .irq_vector(irq_vector),
    .timer0_overflow_flag(timer0_overflow_flag), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
    .ram_access_block(ram_access_block), .addr_latch_strobe(addr_latch_strobe),
    .prog_store_strobe(prog_store_strobe), .port0_float(port0_float), .port2_drive_addr(port2_drive_addr));

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the enable mask and wake block
// Assumes: Bus answers after one wait cycle
// Notes: Source bits ext0, t0, ext1, t1, serial, t2
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [7:0] ie; logic [5:0] s; logic pend; logic [2:0] vec;} row_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [5:0] src = 6'h00;
    logic t2_in = 1'b1;
    logic [1:0] t2_mode = 2'h0;
    logic ext_prog_mem = 1'b1;
    logic ack_en = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, state2_phase2, state5_phase2, irq_ack, irq_pending, cpu_halt, osc_stop;
    logic ram_access_block, addr_latch_strobe, prog_store_strobe, port0_float, port2_drive_addr;
    logic t0_flag, t1_flag;
    logic [2:0] irq_ack_vector, irq_vector;
    logic [3:0] pins;
    // Strobe and port pin states, packed for compares
    assign pins = {addr_latch_strobe, prog_store_strobe, port0_float, port2_drive_addr};
    int num_errors = 0;
    int n_checks = 0;
    // Single-source, global-off, masked-source and priority cases: mask, source, expected request and vector
    row_t rows [10] = '{'{8'h81, 6'h01, 1'b1, 3'h0}, '{8'h82, 6'h02, 1'b1, 3'h1}, '{8'h84, 6'h04, 1'b1, 3'h2},
        '{8'h88, 6'h08, 1'b1, 3'h3}, '{8'h90, 6'h10, 1'b1, 3'h4}, '{8'ha0, 6'h20, 1'b1, 3'h5},
        '{8'h01, 6'h01, 1'b0, 3'h0}, '{8'hbe, 6'h01, 1'b0, 3'h0}, '{8'h85, 6'h05, 1'b1, 3'h0},
        '{8'h83, 6'h03, 1'b1, 3'h0}};
    always #50 core_clk = ~core_clk;
    irq_wake_ctrl u_irq_wake_ctrl (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .state2_phase2(state2_phase2), .state5_phase2(state5_phase2),
        .ext_request_0(src[0]), .timer0_overflow(src[1]), .ext_request_1(src[2]), .timer1_overflow(src[3]),
        .serial_irq(src[4]), .timer2_overflow(src[5]), .timer2_external_input(t2_in), .timer2_mode(t2_mode),
        .irq_ack(irq_ack), .irq_ack_vector(irq_ack_vector), .ext_prog_mem(ext_prog_mem),
        .irq_pending(irq_pending), .irq_vector(irq_vector), .timer0_overflow_flag(t0_flag),
        .timer1_overflow_flag(t1_flag), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
        .ram_access_block(ram_access_block), .addr_latch_strobe(addr_latch_strobe),
        .prog_store_strobe(prog_store_strobe), .port0_float(port0_float), .port2_drive_addr(port2_drive_addr));
    core_model u_core_model (.core_clk(core_clk), .reset_n(reset_n), .ack_en(ack_en),
        .irq_pending(irq_pending), .irq_vector(irq_vector), .state2_phase2(state2_phase2),
        .state5_phase2(state5_phase2), .irq_ack(irq_ack), .irq_ack_vector(irq_ack_vector));
    // ************************************************************
    // Tasks
    // ************************************************************
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
            n++;
        end
        chk("bus waits", 32'h1, 32'(n));
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task rdc(input string w, input logic [3:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(w, {24'h0, e}, q);
    endtask : rdc
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // Watchdog, far beyond the several hundred cycles the run needs
    initial begin
        #3000000;
        num_errors++;
        finish_test();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [31:0] q;
        int n;
        cyc(4);
        reset_n <= 1'b1;
        rdc("mask reset", irq_wake_pkg::ADDR_IE, 8'h00);
        rdc("t2 ctl reset", irq_wake_pkg::ADDR_T2CTL, 8'h00);
        rdc("unmapped", 4'h2, 8'h00);
        foreach (rows[i]) begin
            wr(irq_wake_pkg::ADDR_IE, rows[i].ie);
            rdc("mask", irq_wake_pkg::ADDR_IE, rows[i].ie & 8'hbf);
            @(posedge core_clk);
            src <= rows[i].s;
            cyc(6);
            src <= rows[i].s & 6'h15;
            cyc(12);
            @(negedge core_clk);
            chk("pending", 32'(rows[i].pend), 32'(irq_pending));
            if (rows[i].pend) chk("vector", 32'(rows[i].vec), 32'(irq_vector));
            chk("timer flags", 32'({rows[i].s[3], rows[i].s[1]}), 32'({t1_flag, t0_flag}));
            @(posedge core_clk);
            src <= 6'h00;
            ack_en <= 1'b1;
            cyc(14);
            if (rows[i].s[5]) rdc("t2 kept", irq_wake_pkg::ADDR_T2CTL, 8'h80);
            wr(irq_wake_pkg::ADDR_T2CTL, 8'h00);
            ack_en <= 1'b0;
            wr(irq_wake_pkg::ADDR_IE, 8'h00);
        end
        // External trigger edge, then baud and up/down modes
        wr(irq_wake_pkg::ADDR_T2CTL, 8'h08);
        t2_in <= 1'b0;
        cyc(4);
        rdc("ext flag", irq_wake_pkg::ADDR_T2CTL, 8'h48);
        wr(irq_wake_pkg::ADDR_T2CTL, 8'h00);
        wr(irq_wake_pkg::ADDR_IE, 8'ha0);
        for (int m = 3; m >= 2; m--) begin
            t2_mode <= 2'(m);
            src <= 6'h20;
            cyc(6);
            src <= 6'h00;
            cyc(12);
            bus(1'b0, irq_wake_pkg::ADDR_T2CTL, 8'h00, q);
            chk("t2 flags", (m == 3) ? 32'h0 : 32'h40, q & ((m == 3) ? 32'hc0 : 32'h40));
            wr(irq_wake_pkg::ADDR_T2CTL, (m == 2) ? 8'h40 : 8'h00);
            cyc(14);
            @(negedge core_clk);
            chk("t2 no request", 32'h0, 32'(irq_pending));
        end
        wr(irq_wake_pkg::ADDR_T2CTL, 8'h00);
        t2_mode <= 2'h0;
        // Idle: halted, registers held, woken by an enabled request
        wr(irq_wake_pkg::ADDR_IE, 8'h81);
        wr(irq_wake_pkg::ADDR_PWR, 8'h01);
        @(negedge core_clk);
        chk("idle halt", 32'h1, 32'(cpu_halt));
        chk("idle pins", 32'hf, 32'(pins));
        rdc("mask in idle", irq_wake_pkg::ADDR_IE, 8'h81);
        src <= 6'h01;
        n = 0;
        while (cpu_halt !== 1'b0 && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        chk("wake", 32'h0, 32'(cpu_halt));
        @(posedge core_clk);
        src <= 6'h00;
        // Power-down: only reset leaves it
        wr(irq_wake_pkg::ADDR_PWR, 8'h02);
        src <= 6'h01;
        ext_prog_mem <= 1'b0;
        cyc(20);
        @(negedge core_clk);
        chk("down held", 32'h1, 32'(osc_stop));
        chk("down pins", 32'h0, 32'(pins));
        @(posedge core_clk);
        src <= 6'h00;
        reset_n <= 1'b0;
        cyc(4);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chk("down left", 32'h0, 32'(osc_stop));
        chk("ram block", 32'h1, 32'(ram_access_block));
        rdc("mask after reset", irq_wake_pkg::ADDR_IE, 8'h00);
        finish_test();
    end
endmodule : tb
